// file: bench/gate_partner.sv
// far-side model: gate sources, pin clock, and capture and special event pulse sources
`timescale 1ns/1ps
`default_nettype none

module gate_partner
(
   input  wire logic  clk_i,
   input  wire logic  run_i,      // pin clock runs while high
   input  wire logic  level_i,    // wanted level of gate source 0
   input  wire logic  cap_i,      // request one capture pulse
   input  wire logic  sev_i,      // request one special event pulse
   output logic [7:0] gate_src_o,
   output logic       gate_cmp_o,
   output logic       ext_clk_o,
   output logic       capture_o,
   output logic       sev_o
);
   logic [6:0] noise = 7'h00;     // unselected sources wander every cycle
   logic       cap_d = 1'b0;      // request history for edge pulses
   logic       sev_d = 1'b0;
   logic [1:0] eph   = 2'h0;      // pin clock phase, four cycles a period

   // sources move just after the edge, as on-chip logic would
   always @(posedge clk_i)
   begin
      noise      <= noise + 7'h01;
      gate_src_o <= {noise, level_i};
      gate_cmp_o <= ~noise[0];
      cap_d      <= cap_i;
      sev_d      <= sev_i;
      capture_o  <= cap_i & ~cap_d; // one cycle only, never a level
      sev_o      <= sev_i & ~sev_d;
   end

   // pin clock runs only while asked for and otherwise stands low
   always @(posedge clk_i)
   begin
      eph <= run_i ? eph + 2'h1 : 2'h0;
   end
   assign ext_clk_o = eph[1];
endmodule

`default_nettype wire

// file: bench/gated_16bit_timer_tb.sv
// self-checking testbench of the gated 16-bit timer
`timescale 1ns/1ps
`default_nettype none

module gated_16bit_timer_tb;
   import gated_timer_pkg::*;
   logic        clk_i;
   logic        rstn_i;
   logic        hsel;
   logic        hwrite;
   logic [1:0]  htrans;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic        hready;
   logic        hresp;
   logic [31:0] hrdata;
   logic [7:0]  gsrc;
   logic        gcmp;
   logic        eclk;
   logic        cap;
   logic        sev;
   logic        md;
   logic        lvl;
   logic        fcap;
   logic        fsev;
   logic        ovf_irq;
   logic        gate_irq;
   logic        wake;
   logic        cmp_ev;
   logic        slp;
   logic        erun;
   int          cmp_n = 0;
   logic [31:0] d;
   int          n_fail;
   int          samples_checked;

   gated_timer i_gated_timer (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
      .hrdata_o(hrdata), .gate_src_i(gsrc), .gate_cmp_i(gcmp), .ext_clk_i(eclk),
      .sleep_i(slp), .md_i(md), .capture_i(cap), .sev_i(sev), .compare_event_o(cmp_ev),
      .ovf_irq_o(ovf_irq), .gate_irq_o(gate_irq), .wake_o(wake));

   gate_partner i_gate_partner (.clk_i(clk_i), .run_i(erun), .level_i(lvl), .cap_i(fcap),
      .sev_i(fsev),
      .gate_src_o(gsrc), .gate_cmp_o(gcmp), .ext_clk_o(eclk), .capture_o(cap), .sev_o(sev));

   // free-running 200 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // compare pulses last one cycle, so they are counted as they pass
   always @(posedge clk_i)
   begin
      if (cmp_ev === 1'b1)
         cmp_n <= cmp_n + 1;
   end

   // one single word transfer; address held until hready, data until hready again
   task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd);
      haddr  <= {18'h00000, idx, 2'b00};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clk_i);
      while (hready !== 1'b1) @(posedge clk_i);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk_i);
      while (hready !== 1'b1) @(posedge clk_i);
      d = hrdata;
   endtask

   // compare an exact value
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // compare a count that may differ by a few cycles of pipeline latency
   task automatic near(input string what, input int exp, input logic [31:0] got);
      samples_checked++;
      if ((^got === 1'bx) || (got + 3 < exp) || (got > exp + 3))
      begin
         n_fail++;
         $display("unexpected %s: expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog: the whole sequence needs well under 3000 cycles
   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      stop_test;
   end

   initial
   begin
      {hsel, hwrite, htrans, haddr, hwdata, md, lvl, fcap, fsev, slp, erun} = '0;
      n_fail = 0;
      samples_checked = 0;
      rstn_i = 1'b0;
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      hsel   <= 1'b1;
      @(posedge clk_i);
      xfer(0, IDX_CTRL, 0); chk("control reset", 0, d);
      xfer(0, IDX_STAT, 0); chk("flags reset", 0, d);
      xfer(0, 12'h3FF, 0); chk("unmapped read", 0, d);
      chk("bus response", 0, hresp);
      xfer(1, IDX_CLK, {27'h0, CS_FOSC});
      // every prescale code over a fixed enabled span of about 66 cycles
      for (int i = 0; i < 4; i++)
      begin
         xfer(1, IDX_CNTL, 0);
         xfer(1, IDX_CNTH, 0);
         xfer(1, IDX_CTRL, {26'h0, i[1:0], 4'h1});
         repeat (64) @(posedge clk_i);
         xfer(1, IDX_CTRL, 0);
         xfer(0, IDX_CNTL, 0); near("prescaled count", 66 >> i, d);
      end
      // wrap from the maximum; interrupt only while on
      xfer(1, IDX_STAT, 32'h14);
      xfer(1, IDX_CNTH, 32'hFF);
      xfer(1, IDX_CNTL, 32'hFE);
      xfer(1, IDX_CTRL, 1);
      repeat (8) @(posedge clk_i);
      chk("overflow irq", 1, ovf_irq);
      xfer(1, IDX_CTRL, 0);
      xfer(0, IDX_STAT, 0); chk("overflow flag", 32'h15, d);
      chk("overflow irq off", 0, ovf_irq);
      // special trigger zeroes the count without overflow; capture copies it
      xfer(1, IDX_STAT, 0);
      xfer(1, IDX_CNTL, 32'h55);
      fcap <= 1'b1;
      xfer(1, IDX_CNTH, 32'h12);
      fcap <= 1'b0;
      fsev <= 1'b1;
      xfer(0, IDX_CCP, 0); chk("captured count", 32'h55, d);
      fsev <= 1'b0;
      xfer(0, IDX_CNTL, 0); chk("count after trigger", 0, d);
      xfer(0, IDX_STAT, 0); chk("no overflow on trigger", 0, d);
      // gate enable, active high, on source 0
      xfer(1, IDX_GATE, 0);
      xfer(1, IDX_GCON, 32'hC0);
      xfer(1, IDX_STAT, 0);
      xfer(1, IDX_CTRL, 1);
      repeat (20) @(posedge clk_i);
      xfer(0, IDX_CNTL, 0); chk("held count", 0, d);
      // drop the flag raised by the polarity change; gate irq enabled
      xfer(1, IDX_STAT, 32'h08);
      lvl <= 1'b1;
      repeat (16) @(posedge clk_i);
      xfer(0, IDX_GCON, 0); chk("gate level", 32'hC4, d);
      lvl <= 1'b0;
      repeat (8) @(posedge clk_i);
      xfer(0, IDX_CNTL, 0); near("gated count", 19, d);
      xfer(0, IDX_STAT, 0); chk("gate event flag", 32'h0A, d);
      chk("gate irq", 1, gate_irq);
      // single pulse: enable, then arm, then two gate pulses
      xfer(1, IDX_GCON, 32'hD0);
      xfer(1, IDX_GCON, 32'hD8);
      xfer(1, IDX_CNTL, 0);
      for (int p = 0; p < 2; p++)
      begin
         lvl <= 1'b1;
         repeat (10) @(posedge clk_i);
         lvl <= 1'b0;
         repeat (8) @(posedge clk_i);
      end
      xfer(0, IDX_GCON, 0); chk("arm after pulse", 32'hD0, d);
      xfer(0, IDX_CNTL, 0); near("one pulse count", 10, d);
      xfer(1, IDX_GCON, 32'hC8);
      xfer(0, IDX_GCON, 0); chk("arm without mode", 32'hC0, d);
      // module disable clears the control registers
      xfer(1, IDX_CTRL, 1);
      md <= 1'b1;
      repeat (3) @(posedge clk_i);
      md <= 1'b0;
      xfer(0, IDX_CTRL, 0); chk("control after disable", 0, d);
      // asleep: unaligned pin clock still counts and its overflow wakes
      xfer(1, IDX_STAT, 32'h04);
      xfer(1, IDX_CNTH, 32'hFF);
      xfer(1, IDX_CNTL, 32'hFD);
      xfer(1, IDX_CTRL, 32'h05);
      slp  <= 1'b1;
      erun <= 1'b1;
      repeat (40) @(posedge clk_i);
      chk("wake on overflow", 1, wake);
      chk("irq needs global enable", 0, ovf_irq);
      erun <= 1'b0;
      // asleep: the system clock source must not count
      xfer(1, IDX_CLK, {27'h0, CS_FOSC});
      xfer(1, IDX_CNTL, 0);
      repeat (20) @(posedge clk_i);
      xfer(0, IDX_CNTL, 0); chk("sleep holds count", 0, d);
      xfer(1, IDX_CTRL, 0);
      slp <= 1'b0;
      // compare mode: one event as the count reaches the compare word
      xfer(1, IDX_CCP, 32'h20);
      xfer(1, IDX_STAT, 32'h20);
      xfer(1, IDX_CTRL, 1);
      repeat (40) @(posedge clk_i);
      chk("compare events", 1, cmp_n);
      stop_test;
   end
endmodule

`default_nettype wire

// file: src/gated_timer.sv
// gated 16-bit timer with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none

module gated_timer
   import gated_timer_pkg::*;
#(
   parameter int NSRC = 8                  // synchronised gate sources
)
(
   input  wire logic            clk_i,
   input  wire logic            rstn_i,
   input  wire logic            ce_i,      // freezes all state when low, except the resets done by md_i
   input  wire logic            hsel_i,
   input  wire logic [31:0]     haddr_i,
   input  wire logic [1:0]      htrans_i,
   input  wire logic            hwrite_i,
   input  wire logic [2:0]      hsize_i,
   input  wire logic [31:0]     hwdata_i,
   input  wire logic            hready_i,
   output logic                 hreadyout_o,
   output logic                 hresp_o,
   output logic [31:0]          hrdata_o,
   input  wire logic [NSRC-1:0] gate_src_i, // asynchronous gate sources
   input  wire logic            gate_cmp_i, // comparator, already synchronous
   input  wire logic            ext_clk_i,  // external timer clock pin
   input  wire logic            sleep_i,    // device asleep
   input  wire logic            md_i,       // module_disable_bit
   input  wire logic            capture_i,  // capture event pulse
   input  wire logic            sev_i,      // special event trigger pulse
   output logic                 compare_event_o,
   output logic                 ovf_irq_o,
   output logic                 gate_irq_o,
   output logic                 wake_o
);

   // software-visible state
   ctrl_type    ctrl;                  // timer_control
   gcon_type    gcon;                  // gate control (level bit unused)
   stat_type    stat;                  // flags and enables
   logic [4:0]  gate_source_select;                   // gate_source_select
   logic [4:0]  cs;                    // clock source select
   logic [15:0] count_value;
   logic [15:0] capture_compare_value;
   logic [7:0]  hi_buf;                // high-byte buffer for wide mode

   // bus pipeline
   logic        wr_pend;               // write data phase pending
   logic        rd_pend;               // read data phase pending
   logic [11:0] dp_idx;                // index latched in address phase

   // synchronisers and edge state
   logic [NSRC-1:0] gsrc_meta;
   logic [NSRC-1:0] gsrc_sync;
   logic            ext_meta;
   logic            ext_sync;
   logic            ext_prev;
   logic            ext_rise_q;        // extra aligning stage
   logic [1:0]      div4;
   logic [2:0]      ps_cnt;
   logic            gp_prev;
   logic            tff;
   logic            g1_prev;
   logic            sp_open;           // single pulse window open
   logic            gate_level;
   logic            lvl_prev;
   logic            match_q;

   // address phase and write strobes
   logic wr_en;
   logic addr_ok;
   assign addr_ok = hsel_i & hready_i & htrans_i[1];
   assign wr_en   = wr_pend & ce_i;

   function automatic logic wr_at(input logic [11:0] idx);
      wr_at = wr_en & (dp_idx == idx);
   endfunction

   // bus pipeline: writes take no wait, reads one wait state
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wr_pend     <= 1'b0;
         rd_pend     <= 1'b0;
         dp_idx      <= '0;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
      else if (ce_i)
      begin
         hresp_o <= 1'b0;              // always OKAY
         wr_pend <= addr_ok & hwrite_i;
         rd_pend <= addr_ok & ~hwrite_i;
         if (addr_ok)
            dp_idx <= haddr_i[13:2];   // upper address bits alias
         // wait state lets a write just before be visible to the read
         hreadyout_o <= ~(addr_ok & ~hwrite_i);
      end
   end

   // read data, built one cycle after the address phase
   logic [31:0] next_rdata;
   always_comb
   begin
      next_rdata = '0;                 // unmapped reads give zero
      case (dp_idx)
         IDX_CTRL: next_rdata[5:0] = ctrl;
         IDX_GCON: next_rdata[7:0] = {gcon[7:3], gate_level, 2'b00};
         IDX_GATE: next_rdata[4:0] = gate_source_select;
         IDX_CLK:  next_rdata[4:0] = cs;
         IDX_STAT: next_rdata[5:0] = stat;
         IDX_CNTL: next_rdata[7:0] = count_value[7:0];
         // wide mode serves the buffered high byte
         IDX_CNTH: next_rdata[7:0] = ctrl.wide_access_enable ? hi_buf
                                                           : count_value[15:8];
         IDX_CCP:  next_rdata[15:0] = capture_compare_value;
         default:  next_rdata = '0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         hrdata_o <= '0;
      else if (ce_i && rd_pend)
         hrdata_o <= next_rdata;
   end

   // control registers; module disable holds them at reset values
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ctrl <= CTRL_RST;
         gate_source_select  <= SEL_RST;
         cs   <= SEL_RST;
      end
      else if (md_i)
      begin
         ctrl <= CTRL_RST;
         gate_source_select  <= SEL_RST;
         cs   <= SEL_RST;
      end
      else
      begin
         if (wr_at(IDX_CTRL))
         begin
            ctrl        <= ctrl_type'(hwdata_i[5:0]);
            ctrl.unused <= 1'b0;
         end
         if (wr_at(IDX_GATE))
            gate_source_select <= hwdata_i[4:0];
         if (wr_at(IDX_CLK))
            cs <= hwdata_i[4:0];
      end
   end

   // pin clock: two-stage sync, then optional aligning stage
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ext_meta   <= 1'b0;
         ext_sync   <= 1'b0;
         ext_prev   <= 1'b0;
         ext_rise_q <= 1'b0;
      end
      else if (ce_i)
      begin
         ext_meta   <= ext_clk_i;
         ext_sync   <= ext_meta;
         ext_prev   <= ext_sync;
         ext_rise_q <= ext_sync & ~ext_prev;
      end
   end

   // gate source synchronisers, one pair per source
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++)
      begin : g_sync
         always_ff @(posedge clk_i or negedge rstn_i)
         begin
            if (!rstn_i)
            begin
               gsrc_meta[gi] <= 1'b0;
               gsrc_sync[gi] <= 1'b0;
            end
            else if (ce_i)
            begin
               gsrc_meta[gi] <= gate_src_i[gi];
               gsrc_sync[gi] <= gsrc_meta[gi];
            end
         end
      end
   endgenerate

   // source clock tick; sleep keeps only the unaligned pin clock
   logic src_tick;
   logic ext_tick;
   logic awake_ok;
   assign ext_tick = ctrl.external_clock_unaligned ? (ext_sync & ~ext_prev)
                                                   : ext_rise_q;
   assign awake_ok = ~sleep_i | (cs == CS_PIN && ctrl.external_clock_unaligned);
   always_comb
   begin
      case (cs)
         CS_FOSC:  src_tick = 1'b1;
         CS_FOSC4: src_tick = (div4 == DIV4_LAST);
         CS_PIN:   src_tick = ext_tick;
         default:  src_tick = 1'b0;    // other sources not wired here
      endcase
      src_tick = src_tick & awake_ok & ~md_i;
   end

   // quarter-rate divider runs freely
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         div4 <= '0;
      else if (ce_i)
         div4 <= div4 + 2'h1;
   end

   // count writes: high byte in wide mode only loads the buffer
   logic cnt_wr;
   logic ps_clr;
   logic [15:0] next_wr_val;
   // spelled out: a function that reads module state never wakes a continuous assignment
   assign cnt_wr = wr_en & ((dp_idx == IDX_CNTL)
                            | ((dp_idx == IDX_CNTH) & ~ctrl.wide_access_enable));
   assign ps_clr = cnt_wr;             // the same writes clear the prescaler
   always_comb
   begin
      next_wr_val = count_value;       // only used while cnt_wr is high
      if (dp_idx == IDX_CNTL)
         next_wr_val = ctrl.wide_access_enable ? {hi_buf, hwdata_i[7:0]}
                                               : {count_value[15:8], hwdata_i[7:0]};
      else if (dp_idx == IDX_CNTH)
         next_wr_val = {hwdata_i[7:0], count_value[7:0]};
   end

   // prescaler: tick when the low bits selected by the code are all one
   logic [2:0] ps_mask;
   logic       ps_tick;
   assign ps_mask = 3'(( 4'h1 << ctrl.prescale_select) - 4'h1);
   assign ps_tick = src_tick & ((ps_cnt & ps_mask) == ps_mask);
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         ps_cnt <= '0;
      else if (md_i || (ce_i && ps_clr))
         ps_cnt <= '0;
      else if (ce_i && src_tick)
         ps_cnt <= ps_cnt + 3'h1;
   end

   // gate path: select, polarity, toggle, single pulse
   logic gsel;
   logic gp_now;
   logic g1;
   logic g1_rise;
   logic g1_fall;
   logic next_open;
   always_comb
   begin
      if (gate_source_select == GSS_CMP)
         gsel = gate_cmp_i;            // already on this clock
      else if (32'(gate_source_select) < NSRC)
         gsel = gsrc_sync[gate_source_select[$clog2(NSRC)-1:0]];
      else
         gsel = 1'b0;
   end
   assign gp_now  = gcon.gate_polarity ? gsel : ~gsel;
   assign g1      = gcon.gate_toggle_enable ? tff : gp_now;
   assign g1_rise = g1 & ~g1_prev;
   assign g1_fall = ~g1 & g1_prev;
   always_comb
   begin
      next_open = sp_open;
      if (!gcon.gate_one_pulse_enable)
         next_open = 1'b0;
      else if (g1_rise && gcon.gate_pulse_arm)
         next_open = 1'b1;
      else if (g1_fall)
         next_open = 1'b0;
   end

   // edge history, toggle flip-flop and gate level
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         gp_prev    <= 1'b0;
         tff        <= 1'b0;
         g1_prev    <= 1'b0;
         sp_open    <= 1'b0;
         gate_level <= 1'b0;
         lvl_prev   <= 1'b0;
      end
      else if (md_i)
      begin
         gp_prev    <= 1'b0;
         tff        <= 1'b0;
         g1_prev    <= 1'b0;
         sp_open    <= 1'b0;
         gate_level <= 1'b0;
         lvl_prev   <= 1'b0;
      end
      else if (ce_i)
      begin
         gp_prev <= gp_now;
         if (!gcon.gate_toggle_enable)
            tff <= 1'b0;
         else if (gp_now && !gp_prev)
            tff <= ~tff;
         g1_prev    <= g1;
         sp_open    <= next_open;
         gate_level <= gcon.gate_one_pulse_enable ? (g1 & next_open) : g1;
         lvl_prev   <= gate_level;
      end
   end

   // gate control bits; hardware clears the arm bit
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         gcon <= GCON_RST;
      else if (md_i)
         gcon <= GCON_RST;
      else if (ce_i)
      begin
         if (wr_at(IDX_GCON))
         begin
            gcon            <= gcon_type'(hwdata_i[7:0]);
            gcon.gate_level <= 1'b0;
            gcon.unused     <= 2'b00;
         end
         else if (sp_open && g1_fall)
            gcon.gate_pulse_arm <= 1'b0;
         if (!gcon.gate_one_pulse_enable || (wr_at(IDX_GCON) && !hwdata_i[4]))
            gcon.gate_pulse_arm <= 1'b0;
      end
   end

   // counter: write beats trigger, trigger beats increment
   logic count_en;
   logic inc;
   logic ovf_evt;
   assign count_en = ctrl.on & (~gcon.gate_count_enable | gate_level);
   assign inc      = ps_tick & count_en;
   assign ovf_evt  = ce_i & inc & ~cnt_wr & ~sev_i & (count_value == MAX_COUNT);
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         count_value <= '0;
      else if (md_i)
         count_value <= '0;
      else if (ce_i)
      begin
         if (cnt_wr)
            count_value <= next_wr_val;
         else if (sev_i)
            count_value <= '0;
         else if (inc)
            count_value <= count_value + 16'h1;
      end
   end

   // high-byte buffer for wide access
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         hi_buf <= '0;
      else if (md_i)
         hi_buf <= '0;
      else if (ce_i)
      begin
         if (rd_pend && dp_idx == IDX_CNTL)
            hi_buf <= count_value[15:8];
         else if (wr_at(IDX_CNTH))
            hi_buf <= hwdata_i[7:0];
      end
   end

   // flags: hardware set wins over a software clear
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         stat <= STAT_RST;
      else if (md_i)
         stat <= STAT_RST;
      else if (ce_i)
      begin
         if (wr_at(IDX_STAT))
            stat <= stat_type'(hwdata_i[5:0]);
         if (ovf_evt)
            stat.overflow_flag <= 1'b1;
         if (lvl_prev && !gate_level)
            stat.gate_event_flag <= 1'b1;
      end
   end

   // capture and compare
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         capture_compare_value <= '0;
         match_q               <= 1'b0;
         compare_event_o       <= 1'b0;
      end
      else if (md_i)
      begin
         capture_compare_value <= '0;
         match_q               <= 1'b0;
         compare_event_o       <= 1'b0;
      end
      else if (ce_i)
      begin
         if (capture_i && !stat.compare_mode)
            capture_compare_value <= count_value;
         else if (wr_at(IDX_CCP))
            capture_compare_value <= hwdata_i[15:0];
         match_q <= (count_value == capture_compare_value);
         compare_event_o <= stat.compare_mode & ~match_q
                            & (count_value == capture_compare_value);
      end
   end

   // interrupt requests and wake, registered
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ovf_irq_o  <= 1'b0;
         gate_irq_o <= 1'b0;
         wake_o     <= 1'b0;
      end
      else if (ce_i)
      begin
         ovf_irq_o  <= ctrl.on & stat.overflow_irq_enable
                       & stat.global_irq_enable & stat.overflow_flag;
         gate_irq_o <= stat.gate_event_irq_enable & stat.gate_event_flag;
         wake_o     <= sleep_i & ctrl.on & stat.overflow_irq_enable
                       & stat.overflow_flag;
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_fall; ce_i && !md_i && lvl_prev && !gate_level; endsequence
   sequence s_gflag; stat.gate_event_flag; endsequence

   chk_off_holds: assert property (ce_i && !md_i && !ctrl.on && !cnt_wr && !sev_i
      |=> $stable(count_value)) else $error("count moved while off");
   chk_gate_hold: assert property (ce_i && !md_i && ctrl.on && gcon.gate_count_enable
      && !gate_level && !cnt_wr && !sev_i |=> $stable(count_value))
      else $error("count moved with gate inactive");
   chk_tff_clear: assert property (ce_i && !md_i && !gcon.gate_toggle_enable
      |=> !tff) else $error("toggle flop not cleared");
   chk_arm_drop: assert property (ce_i && !md_i && !gcon.gate_one_pulse_enable
      |=> !gcon.gate_pulse_arm) else $error("arm kept without one-pulse");
   chk_gate_flag: assert property (s_fall |=> s_gflag)
      else $error("gate fall missed");
   chk_wrap_flag: assert property (ovf_evt && !md_i
      |=> count_value == 16'h0000 && stat.overflow_flag) else $error("wrap wrong");
   chk_sev_clear: assert property (ce_i && !md_i && sev_i && !cnt_wr
      |=> count_value == 16'h0000 && !$rose(stat.overflow_flag))
      else $error("trigger did not clear quietly");
   chk_md_reset: assert property (md_i |=> count_value == 16'h0000 && ctrl == CTRL_RST)
      else $error("disable did not reset");
   chk_ovf_irq: assert property (ovf_irq_o |-> $past(ctrl.on)
      && $past(stat.global_irq_enable)) else $error("overflow irq unqualified");
   chk_read_wait: assert property (addr_ok && !hwrite_i && ce_i
      |=> !hreadyout_o ##1 hreadyout_o [*1]) else $error("read timing");

endmodule

`default_nettype wire

// file: src/gated_timer_pkg.sv
// shared constants and carrier types of the gated 16-bit timer
package gated_timer_pkg;

   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_CTRL = 12'h30E; // timer_control
   localparam logic [11:0] IDX_GCON = 12'h30F; // gate control
   localparam logic [11:0] IDX_GATE = 12'h310; // gate source select
   localparam logic [11:0] IDX_CLK  = 12'h311; // clock source select
   localparam logic [11:0] IDX_STAT = 12'h320; // flags and enables
   localparam logic [11:0] IDX_CNTL = 12'h321; // count low byte
   localparam logic [11:0] IDX_CNTH = 12'h322; // count high byte
   localparam logic [11:0] IDX_CCP  = 12'h323; // capture/compare word

   // clock source codes
   localparam logic [4:0] CS_PIN   = 5'h00; // external pin
   localparam logic [4:0] CS_FOSC4 = 5'h01; // system clock / 4
   localparam logic [4:0] CS_FOSC  = 5'h02; // system clock
   // gate source code of the already-synchronous comparator
   localparam logic [4:0] GSS_CMP  = 5'h12;

   localparam logic [1:0]  DIV4_LAST = 2'h3;    // last phase of /4
   localparam logic [15:0] MAX_COUNT = 16'hFFFF;
   localparam logic [4:0]  SEL_RST   = 5'h00;  // both select fields

   // timer_control layout, bit 5 down to bit 0
   typedef struct packed {
      logic [1:0] prescale_select;
      logic       unused;
      logic       external_clock_unaligned;
      logic       wide_access_enable;
      logic       on;
   } ctrl_type;

   // gate control layout, bit 7 down to bit 0
   typedef struct packed {
      logic       gate_count_enable;
      logic       gate_polarity;
      logic       gate_toggle_enable;
      logic       gate_one_pulse_enable;
      logic       gate_pulse_arm;
      logic       gate_level;
      logic [1:0] unused;
   } gcon_type;

   // flags and enables layout, bit 5 down to bit 0
   typedef struct packed {
      logic compare_mode;
      logic global_irq_enable;
      logic gate_event_irq_enable;
      logic overflow_irq_enable;
      logic gate_event_flag;
      logic overflow_flag;
   } stat_type;

   localparam ctrl_type CTRL_RST = '0;
   localparam gcon_type GCON_RST = '0;
   localparam stat_type STAT_RST = '0;

endpackage
